/* tb/board_pins.sv */
// Board model that resolves the port-one pin levels.
`default_nettype none
module board_pins (
   // Clock and block side.
   input  wire logic       sys_clk,
   input  wire logic [7:0] p1_pin_out,
   input  wire logic [7:0] p1_pin_oe,
   input  wire logic [7:0] p1_pullup_on,
   // Board drive and resolved levels.
   input  wire logic [7:0] ext_en,
   input  wire logic [7:0] ext_level,
   output wire logic [7:0] p1_pin_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] float_level = 8'h55;
   // An undriven pin without pull-up wanders, so it never reads as a settled value.
   always @(posedge sys_clk) float_level <= ~float_level;
   assign p1_pin_in = (p1_pin_oe & p1_pin_out) | (~p1_pin_oe & ext_en & ext_level)
      | (~p1_pin_oe & ~ext_en & (p1_pullup_on | float_level));
endmodule
`default_nettype wire

/* tb/gpio_pins_monitor.sv */
// Checker of port one and port two pin control, watching the block's ports.
`default_nettype none
module gpio_pins_monitor (
   // Clock, reset and APB.
   input wire logic        sys_clk,
   input wire logic        resetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   // Pins and alternate functions.
   input wire logic [7:0]  p1_pin_out,
   input wire logic [7:0]  p1_pin_oe,
   input wire logic [7:0]  p1_pullup_on,
   input wire logic        timer_waveform_output,
   input wire logic        ext_interrupt_line_three,
   input wire logic        timer_trigger_input,
   input wire logic [2:0]  p2_pin_oe,
   input wire logic [2:0]  serial_claim,
   input wire logic [2:0]  serial_drive_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   sequence s_wr(int idx);
      psel && penable && pwrite && pstrb[0] && paddr[11:2] == idx;
   endsequence
   a_pin3_undriven: assert property (p1_pin_oe[3] == 1'b0)
      else $error("pin three driven");
   a_pullup_out_off: assert property ((p1_pin_oe & p1_pullup_on) == 8'h00)
      else $error("pull-up on a driven pin");
   a_trig_irq_same: assert property (timer_trigger_input == ext_interrupt_line_three)
      else $error("trigger and top interrupt differ");
   a_latch_to_pin: assert property (s_wr(0) |=> p1_pin_out[2:1] == $past(pwdata[2:1]))
      else $error("latch not on pins");
   a_dir_to_oe: assert property (s_wr(1) |=> p1_pin_oe[2:1] == $past(pwdata[2:1]))
      else $error("direction not on pins");
   a_pullup_follows: assert property (s_wr(2) |=>
      p1_pullup_on[2:1] == ($past(pwdata[2:1]) & ~p1_pin_oe[2:1])) else $error("pull-up wrong");
   a_serial_claim_wins: assert property (
      ((p2_pin_oe ^ serial_drive_oe) & serial_claim & 3'h3) == 3'h0) else $error("claim lost");
   a_alt_pin0: assert property (s_wr(3) ##0 pwdata[0] |=>
      p1_pin_oe[0] && p1_pin_out[0] == timer_waveform_output) else $error("timer output lost");
endmodule
`default_nettype wire

/* tb/port1_port2_gpio_tb_top.sv */
// Testbench of port one and port two pin control.
`default_nettype none
module port1_port2_gpio_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        sys_clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        timer_waveform_output = 1'b0, pready, pslverr, err;
   logic        ext_interrupt_line_three, ext_interrupt_line_two, ext_interrupt_line_one;
   logic        ext_interrupt_line_zero, timer_trigger_input;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [3:0]  pstrb = 4'hF;
   logic [7:0]  p1_pin_in, p1_pin_out, p1_pin_oe, p1_pullup_on, ext_en = 8'hFF, ext_level = 8'hA5;
   logic [2:0]  p2_pin_in, p2_pin_out, p2_pin_oe, p2_pin_level, serial_claim = 3'h0;
   logic [2:0]  port2_gpio_data = 3'h5, serial_drive_out = 3'h2, serial_drive_oe = 3'h0;
   int          fails = 0, check_count = 0, cycles = 0;
   assign p2_pin_in = (p2_pin_oe & p2_pin_out) | ~p2_pin_oe;
   port1_port2_gpio dut (.*);
   board_pins board (.sys_clk, .p1_pin_out, .p1_pin_oe, .p1_pullup_on, .ext_en, .ext_level,
      .p1_pin_in);
   always #5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         fails = fails + 1;
         end_of_test();
      end
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count = check_count + 1;
      if (got !== exp) begin
         fails = fails + 1;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1) @(posedge sys_clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic end_of_test();
      $display("Checks %0d, mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge sys_clk);
      resetn <= 1'b1;
      repeat (3) @(posedge sys_clk);
      chk("idle lines", 32'h1F, {27'h0, timer_trigger_input, ext_interrupt_line_three,
         ext_interrupt_line_two, ext_interrupt_line_one, ext_interrupt_line_zero});
      apb(1'b0, 12'h000, 8'h00);
      chk("input readback", 32'hAD, rd);
      apb(1'b0, 12'h008, 8'h00);
      chk("pull-up reset", 32'h08, rd);
      $display("reset test done");
      apb(1'b1, 12'h004, 8'hF0);
      apb(1'b1, 12'h000, 8'hFF);
      chk("direction on pins", 32'hF0, {24'h0, p1_pin_oe});
      apb(1'b0, 12'h000, 8'h00);
      chk("mixed readback", 32'hFD, rd);
      apb(1'b1, 12'h000, 8'h0F);
      apb(1'b0, 12'h000, 8'h00);
      chk("latch readback", 32'h0D, rd);
      $display("latch test done");
      ext_en <= 8'h00;
      apb(1'b1, 12'h008, 8'hFF);
      chk("pull-ups on", 32'h07, {24'h0, p1_pullup_on});
      apb(1'b0, 12'h008, 8'h00);
      chk("pull-up readback", 32'hFF, rd);
      apb(1'b1, 12'h008, 8'h00);
      apb(1'b0, 12'h008, 8'h00);
      chk("pull-up bit three", 32'h08, rd);
      $display("pull-up test done");
      ext_en <= 8'hFF;
      ext_level <= 8'h50;
      timer_waveform_output <= 1'b0;
      apb(1'b1, 12'h00C, 8'hF1);
      repeat (2) @(posedge sys_clk);
      chk("alternate drive", 32'h01, {24'h0, p1_pin_oe});
      chk("timer on pin", 32'h0, {31'h0, p1_pin_out[0]});
      chk("interrupt lines", 32'h05, {27'h0, timer_trigger_input,
         ext_interrupt_line_three, ext_interrupt_line_two, ext_interrupt_line_one,
         ext_interrupt_line_zero});
      apb(1'b0, 12'h00C, 8'h00);
      chk("select readback", 32'hFD, rd);
      apb(1'b1, 12'h00C, 8'h00);
      chk("direction reapplied", 32'hF0, {24'h0, p1_pin_oe});
      apb(1'b0, 12'h000, 8'h00);
      chk("latch kept", 32'h08, rd);
      $display("alternate function test done");
      apb(1'b1, 12'h010, 8'hFF);
      chk("port two outputs", 32'h7, {29'h0, p2_pin_oe});
      apb(1'b0, 12'h010, 8'h00);
      chk("port two readback", 32'h0, rd);
      serial_claim <= 3'h2;
      @(posedge sys_clk);
      chk("serial claim", 32'h5, {29'h0, p2_pin_oe});
      chk("serial data", 32'h7, {29'h0, p2_pin_out});
      apb(1'b1, 12'h00C, 8'h02);
      repeat (2) @(posedge sys_clk);
      chk("serial tx pin", 32'h3, {29'h0, p2_pin_out});
      chk("port two levels", 32'h3, {29'h0, p2_pin_level});
      apb(1'b0, 12'h020, 8'h00);
      chk("unmapped error", 32'h1, {31'h0, err});
      pstrb <= 4'hE;
      apb(1'b1, 12'h000, 8'hFF);
      pstrb <= 4'hF;
      apb(1'b0, 12'h000, 8'h00);
      chk("strobe ignored", 32'h08, rd);
      $display("port two test done");
      end_of_test();
   end
endmodule
bind port1_port2_gpio gpio_pins_monitor mon (.*);
`default_nettype wire

/* verilog/pin_sync2.v */
// Two flip-flop synchroniser for a group of pin levels.
`default_nettype none

module pin_sync2 #(
   parameter WIDTH = 8
) (
   // Clock and reset.
   input  wire             sys_clk,
   input  wire             resetn,
   // Levels from outside the clock domain and their synchronised copies.
   input  wire [WIDTH-1:0] async_level,
   output reg  [WIDTH-1:0] sync_level
);

   reg [WIDTH-1:0] stage_one;

   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         stage_one <= {WIDTH{1'b0}};
         sync_level <= {WIDTH{1'b0}};
      end else begin
         stage_one <= async_level;
         sync_level <= stage_one;
      end
   end

endmodule

`default_nettype wire

/* verilog/port1_port2_gpio.v */
// General I/O for port one and the control part of port two, with an APB register slave.
//
// What this block does
// (RL1) Each usable port-one bit (7 to 4, 2 to 0) has a writable output latch, reset to zero, driven onto the pin when it is a general I/O output.
// (RL2) Reading the port-one data register returns the latch value for each bit set as output.
// (RL3) Reading the port-one data register returns the sampled pin level for each bit set as input.
// (RL4) Bit three of the port-one data and pull-up registers stores nothing, ignores writes and reads as one.
// (RL5) A port-one pull-up acts only while its pin's direction bit is zero.
// (RL6) On a valid general I/O input pin the pull-up is on when its enable bit is one and off when zero; enables reset to zero.
// (RL7) Select bit zero leaves pins 6, 5, 4 and 0 general I/O; one makes 6 to 4 interrupt inputs and 0 the timer output.
// (RL8) With its select bit set, pin 7 feeds the highest interrupt input and the timer trigger, ignoring direction.
// (RL9) On port two the select register and the serial unit override the general direction when they claim a pin.
// (RL10) A port-two direction bit of one makes a general pin an output and zero an input; reset is zero.
// (RL11) The port-two direction register holds only bits 2 to 0, write-only; the upper bits are reserved.
// (RL12) Port-one direction bits are write-only, reset to zero and act only on general I/O pins, one meaning output.
// (RL13) Handing a pin to an alternate function leaves its latch, direction and pull-up enable untouched.
`default_nettype none
`include "port1_port2_gpio_defs.vh"

module port1_port2_gpio (
   // Clock and reset.
   input  wire        sys_clk,
   input  wire        resetn,
   // APB slave.
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   input  wire [3:0]  pstrb,
   output wire        pready,
   output reg  [31:0] prdata,
   output reg         pslverr,
   // Port one pins.
   input  wire [7:0]  p1_pin_in,
   output wire [7:0]  p1_pin_out,
   output wire [7:0]  p1_pin_oe,
   output wire [7:0]  p1_pullup_on,
   // Port one alternate functions.
   input  wire        timer_waveform_output,
   output wire        ext_interrupt_line_three,
   output wire        ext_interrupt_line_two,
   output wire        ext_interrupt_line_one,
   output wire        ext_interrupt_line_zero,
   output wire        timer_trigger_input,
   // Port two pins.
   input  wire [2:0]  p2_pin_in,
   output wire [2:0]  p2_pin_out,
   output wire [2:0]  p2_pin_oe,
   output wire [2:0]  p2_pin_level,
   // Port two general output data and serial unit claims.
   input  wire [2:0]  port2_gpio_data,
   input  wire [2:0]  serial_claim,
   input  wire [2:0]  serial_drive_out,
   input  wire [2:0]  serial_drive_oe
);

   reg  [7:0]  port1_output_latch;
   reg  [7:0]  port1_direction_bits;
   reg  [7:0]  port1_pullup_enables;
   reg  [7:0]  pin_function_select_reg;
   reg  [2:0]  port2_direction_bits;

   wire [7:0]  p1_level;
   wire [7:0]  p1_alt;
   wire [7:0]  p1_alt_out;
   wire [7:0]  p1_alt_oe;
   wire [7:0]  p1_general_out;
   wire [2:0]  p2_claim;
   wire [2:0]  p2_claim_oe;
   wire [7:0]  p1_read_value;

   wire        setup_phase;
   wire        write_access;
   wire        byte0_write;
   reg  [31:0] next_prdata;
   reg         next_pslverr;

   // Address decode of one register word.
   function reg_hit;
      input [11:0] addr;
      input [11:0] offset;
      begin
         reg_hit = (addr[11:2] == offset[11:2]);
      end
   endfunction

   // Merges a written byte into a register, keeping only implemented bits.
   function [7:0] masked_write;
      input [7:0] old_value;
      input [7:0] new_value;
      input [7:0] mask;
      begin
         masked_write = (new_value & mask) | (old_value & ~mask);
      end
   endfunction

   // Pin synchronisers.
   pin_sync2 #(
      .WIDTH (8)
   ) u_p1_sync (
      .sys_clk     (sys_clk),
      .resetn      (resetn),
      .async_level (p1_pin_in),
      .sync_level  (p1_level)
   );

   pin_sync2 #(
      .WIDTH (3)
   ) u_p2_sync (
      .sys_clk     (sys_clk),
      .resetn      (resetn),
      .async_level (p2_pin_in),
      .sync_level  (p2_pin_level)
   );

   // Bus strobes.
   assign pready = 1'b1;
   assign setup_phase = psel & ~penable;
   assign write_access = psel & penable & pwrite;
   assign byte0_write = write_access & pstrb[0];

   // Register writes; alternate functions never touch stored values.
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         port1_output_latch <= `P1_LATCH_RESET;
         port1_direction_bits <= `P1_DIR_RESET;
         port1_pullup_enables <= `P1_PULLUP_RESET;
         pin_function_select_reg <= `FUNC_SEL_RESET;
         port2_direction_bits <= `P2_DIR_RESET;
      end else if (byte0_write) begin
         if (reg_hit(paddr, `P1_LATCH_OFFSET)) begin
            port1_output_latch <= masked_write(port1_output_latch, pwdata[7:0],
                                               `P1_USABLE_MASK); // see RL1, RL4, RL13
         end
         if (reg_hit(paddr, `P1_DIR_OFFSET)) begin
            port1_direction_bits <= masked_write(port1_direction_bits, pwdata[7:0],
                                                 `P1_USABLE_MASK); // see RL12
         end
         if (reg_hit(paddr, `P1_PULLUP_OFFSET)) begin
            port1_pullup_enables <= masked_write(port1_pullup_enables, pwdata[7:0],
                                                 `P1_USABLE_MASK); // see RL4, RL6
         end
         if (reg_hit(paddr, `FUNC_SEL_OFFSET)) begin
            pin_function_select_reg <= masked_write(pin_function_select_reg, pwdata[7:0],
                                                    `FUNC_SEL_MASK);
         end
         if (reg_hit(paddr, `P2_DIR_OFFSET)) begin
            port2_direction_bits <= pwdata[2:0] & `P2_USABLE_MASK; // see RL11
         end
      end
   end

   // Port one readback: latch for outputs, pin level for inputs, bit three as one.
   assign p1_read_value = ((port1_output_latch & port1_direction_bits)       // see RL2
                        | (p1_level & ~port1_direction_bits)                 // see RL3
                        | ~`P1_USABLE_MASK) ;                                // see RL4

   // Read data is prepared in the setup cycle so it stands in the access cycle.
   always @* begin
      next_prdata = 32'h00000000;
      next_pslverr = 1'b0;
      if (reg_hit(paddr, `P1_LATCH_OFFSET)) begin
         next_prdata = {24'h000000, p1_read_value};
      end else if (reg_hit(paddr, `P1_DIR_OFFSET)) begin
         next_prdata = 32'h00000000;
      end else if (reg_hit(paddr, `P1_PULLUP_OFFSET)) begin
         next_prdata = {24'h000000, port1_pullup_enables | ~`P1_USABLE_MASK}; // see RL4
      end else if (reg_hit(paddr, `FUNC_SEL_OFFSET)) begin
         next_prdata = {24'h000000, pin_function_select_reg | `FUNC_SEL_ONES};
      end else if (reg_hit(paddr, `P2_DIR_OFFSET)) begin
         next_prdata = 32'h00000000; // see RL11
      end else begin
         next_pslverr = 1'b1;
      end
      if (pwrite) begin
         next_prdata = 32'h00000000;
      end
   end

   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else if (setup_phase) begin
         prdata <= next_prdata;
         pslverr <= next_pslverr;
      end else if (!psel) begin
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end
   end

   // Port one alternate function ownership.
   assign p1_alt = {pin_function_select_reg[`FSEL_EXT_INTERRUPT_LINE_THREE_BIT],          // see RL8
                    pin_function_select_reg[`FSEL_EXT_INTERRUPT_LINE_TWO_BIT],          // see RL7
                    pin_function_select_reg[`FSEL_EXT_INTERRUPT_LINE_ONE_BIT],
                    pin_function_select_reg[`FSEL_EXT_INTERRUPT_LINE_ZERO_BIT],
                    1'b0,
                    1'b0,
                    1'b0,
                    pin_function_select_reg[`FSEL_TIMER_OUT_BIT]};
   assign p1_alt_out = {7'h00, timer_waveform_output};
   assign p1_alt_oe = {7'h00, 1'b1};
   assign p1_general_out = port1_output_latch & `P1_USABLE_MASK;

   // Port one pin drive: alternate function first, then direction.
   assign p1_pin_out = (p1_alt & p1_alt_out) | (~p1_alt & p1_general_out);         // see RL1, RL7
   assign p1_pin_oe = ((p1_alt & p1_alt_oe)
                    | (~p1_alt & port1_direction_bits)) & `P1_USABLE_MASK;        // see RL7, RL8, RL12

   // Pull-ups act only on general pins set as inputs.
   assign p1_pullup_on = port1_pullup_enables & ~port1_direction_bits
                       & ~p1_alt & `P1_USABLE_MASK;                                // see RL5, RL6

   // Interrupt and trigger inputs idle high while their pin is general I/O.
   assign ext_interrupt_line_three = p1_alt[7] ? p1_level[7] : 1'b1; // see RL8
   assign timer_trigger_input = p1_alt[7] ? p1_level[7] : 1'b1;      // see RL8
   assign ext_interrupt_line_two = p1_alt[6] ? p1_level[6] : 1'b1;   // see RL7
   assign ext_interrupt_line_one = p1_alt[5] ? p1_level[5] : 1'b1;   // see RL7
   assign ext_interrupt_line_zero = p1_alt[4] ? p1_level[4] : 1'b1;  // see RL7

   // Port two: select register and serial unit claims override direction.
   assign p2_claim = serial_claim
                   | {pin_function_select_reg[`FSEL_SERIAL_TX_BIT], 2'b00};      // see RL9
   assign p2_claim_oe = serial_drive_oe
                      | {pin_function_select_reg[`FSEL_SERIAL_TX_BIT], 2'b00};   // see RL9
   assign p2_pin_out = (p2_claim & serial_drive_out)
                     | (~p2_claim & port2_gpio_data);                            // see RL9
   assign p2_pin_oe = (p2_claim & p2_claim_oe)
                    | (~p2_claim & port2_direction_bits);                        // see RL10

endmodule

`default_nettype wire

/* verilog/port1_port2_gpio_defs.vh */
// Register offsets, field positions, reset values and masks of the port one and two block.
`ifndef PORT1_PORT2_GPIO_DEFS_VH
`define PORT1_PORT2_GPIO_DEFS_VH

`define P1_LATCH_OFFSET    12'h000
`define P1_DIR_OFFSET      12'h004
`define P1_PULLUP_OFFSET   12'h008
`define FUNC_SEL_OFFSET    12'h00C
`define P2_DIR_OFFSET      12'h010

`define P1_USABLE_MASK     8'hF7
`define P1_RESERVED_BIT    3
`define FUNC_SEL_MASK      8'hF3
`define FUNC_SEL_ONES      8'h0C
`define P2_USABLE_MASK     3'h7

`define P1_LATCH_RESET     8'h00
`define P1_DIR_RESET       8'h00
`define P1_PULLUP_RESET    8'h00
`define FUNC_SEL_RESET     8'h00
`define P2_DIR_RESET       3'h0

`define FSEL_TIMER_OUT_BIT 0
`define FSEL_SERIAL_TX_BIT 1
`define FSEL_EXT_INTERRUPT_LINE_ZERO_BIT      4
`define FSEL_EXT_INTERRUPT_LINE_ONE_BIT      5
`define FSEL_EXT_INTERRUPT_LINE_TWO_BIT      6
`define FSEL_EXT_INTERRUPT_LINE_THREE_BIT      7

`define P2_SERIAL_TX_PIN   2

`endif
